//--- verilog/twm_pkg.sv
/*
  Constants, mode table and helpers for the 16-bit timer waveform-mode control.
  Assumes one system clock; CPU accesses arrive as one-cycle byte strobes.
*/
// What this block does
// - Counter write blocks matches next timer cycle
// - Written value equal compare gives no match
// - Written TOP in variable-TOP mode: count on
// - Output state kept across mode changes
// - Output action bits act immediately
// - Mode 0: TOP FFFF, immediate, flag at MAX
// - Modes 1-3 phase correct fixed TOP
// - Modes 4, 12 clear on match
// - Modes 5-7 fast PWM fixed TOP
// - Modes 8, 9 phase-frequency correct
// - Modes 10, 11 phase correct variable TOP
// - Modes 14, 15 fast PWM variable TOP
// - Filter needs four equal samples
// - Edge select: one rising, zero falling
// - Force strobe drives output in non-PWM modes, no flag
// - High byte held, low write commits both
// - Filter runs on system clock
package twm_pkg;

  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [7:0] CTRLB_RESET = 8'h00;
  localparam int CTRLB_FILTER_BIT = 7;
  localparam int CTRLB_EDGE_BIT = 6;
  localparam int CTRLB_MODE3_BIT = 4;
  localparam int CTRLB_MODE2_BIT = 3;
  localparam int CTRLB_CLKSEL_MSB = 2;
  localparam logic [1:0] MODE_LOW_RESET = 2'h0;
  localparam int FILTER_SAMPLES = 4;

  // Output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  typedef enum logic [2:0] {
    TWM_TOP_FIXED = 3'h1,
    TWM_TOP_COMPARE = 3'h2,
    TWM_TOP_CAPTURE = 3'h4
  } twm_topsrc_type;

  typedef enum logic [2:0] {
    TWM_UPD_IMMEDIATE = 3'h1,
    TWM_UPD_TOP = 3'h2,
    TWM_UPD_BOTTOM = 3'h4
  } twm_update_type;

  typedef enum logic [2:0] {
    TWM_OVF_MAX = 3'h1,
    TWM_OVF_TOP = 3'h2,
    TWM_OVF_BOTTOM = 3'h4
  } twm_ovf_type;

  // Fixed TOP for modes with constant resolution
  function automatic logic [15:0] twm_fixed_top(input logic [3:0] mode);
    unique case (mode[1:0])
      2'h1: twm_fixed_top = TOP_8BIT;
      2'h2: twm_fixed_top = TOP_9BIT;
      2'h3: twm_fixed_top = TOP_10BIT;
      default: twm_fixed_top = TOP_MAX;
    endcase
  endfunction

  // Dual-slope counting
  function automatic logic twm_dual_slope(input logic [3:0] mode);
    twm_dual_slope = (mode inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11});
  endfunction

  // PWM modes (force strobe ignored)
  function automatic logic twm_is_pwm(input logic [3:0] mode);
    twm_is_pwm = !(mode inside {4'd0, 4'd4, 4'd12, 4'd13});
  endfunction

endpackage

//--- verilog/twm_capture_filter.sv
/*
  Capture input filter and edge detector.
  Assumes the capture pin is already synchronous to ref_clk.
*/
module twm_capture_filter
  import twm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic capturePin,
  input wire logic filterEnable,
  input wire logic edgeRising,
  output logic captureEvent
);
  import twm_pkg::*;

  logic [FILTER_SAMPLES-1:0] hist_q, hist_d;
  logic filt_q, filt_d;
  logic prev_q, prev_d;
  logic src;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    hist_d = {hist_q[FILTER_SAMPLES-2:0], capturePin};
    filt_d = filt_q;
    if (&hist_q)
    begin
      filt_d = 1'b1;
    end
    else if (~|hist_q)
    begin
      filt_d = 1'b0;
    end
    src = filterEnable ? filt_q : capturePin;
    prev_d = src;
    captureEvent = (src != prev_q) && (src == edgeRising);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      hist_q <= '0;
      filt_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      hist_q <= hist_d;
      filt_q <= filt_d;
      prev_q <= prev_d;
    end
  end
endmodule

//--- verilog/twm_compare_out.sv
/*
  One compare channel: buffered compare value and output state.
  Assumes strobes are one-cycle pulses on ref_clk.
*/
module twm_compare_out
  import twm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic writeStrobe,
  input wire logic [15:0] writeData,
  input wire logic updateNow,
  input wire logic immediate,
  input wire logic matchFire,
  input wire logic forceStrobe,
  input wire logic [1:0] action,
  output logic [15:0] compareValue,
  output logic outState
);
  import twm_pkg::*;

  logic [15:0] buf_q, buf_d, cmp_q, cmp_d;
  logic out_q, out_d;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    buf_d = writeStrobe ? writeData : buf_q;
    cmp_d = cmp_q;
    if (writeStrobe && immediate)
    begin
      cmp_d = writeData;
    end
    else if (updateNow && !immediate)
    begin
      cmp_d = buf_q;
    end
    out_d = out_q;
    if (matchFire || forceStrobe)
    begin
      unique case (action)
        ACT_TOGGLE: out_d = ~out_q;
        ACT_CLEAR: out_d = 1'b0;
        ACT_SET: out_d = 1'b1;
        ACT_NONE: out_d = out_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      buf_q <= '0;
      cmp_q <= '0;
      out_q <= 1'b0;
    end
    else
    begin
      buf_q <= buf_d;
      cmp_q <= cmp_d;
      out_q <= out_d;
    end
  end

  assign compareValue = cmp_q;
  assign outState = out_q;
endmodule

//--- verilog/twm_timer16.sv
/*
  16-bit timer waveform-mode control with byte-wide register access.
  Assumes CPU write/read strobes are one-cycle and synchronous to ref_clk.
*/
module twm_timer16
  import twm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic timerTick,
  input wire logic [7:0] writeData,
  input wire logic countHighWrite,
  input wire logic countLowWrite,
  input wire logic compareAHighWrite,
  input wire logic compareALowWrite,
  input wire logic compareBHighWrite,
  input wire logic compareBLowWrite,
  input wire logic captureHighWrite,
  input wire logic captureLowWrite,
  input wire logic controlAWrite,
  input wire logic controlBWrite,
  input wire logic forceStrobeA,
  input wire logic forceStrobeB,
  input wire logic capture_input_pin,
  output logic [15:0] count_value,
  output logic [15:0] capture_value,
  output logic [7:0] timer1_control_b,
  output logic [7:0] controlA,
  output logic compare_output_a,
  output logic compare_output_b,
  output logic overflowPulse,
  output logic compareMatchPulseA,
  output logic compareMatchPulseB,
  output logic capturePulse
);
  import twm_pkg::*;

  logic [7:0] temp_q, temp_d;
  logic [15:0] cnt_q, cnt_d, cap_q, cap_d;
  logic [7:0] ctlA_q, ctlA_d, ctlB_q, ctlB_d;
  logic down_q, down_d;
  logic block_q, block_d;
  logic ovf_q, ovf_d, mA_q, mA_d, mB_q, mB_d, capP_q, capP_d;
  logic [3:0] mode;
  logic [15:0] top, cmpA, cmpB, wordIn;
  twm_topsrc_type topSrc;
  twm_update_type updSel;
  twm_ovf_type ovfSel;
  logic atTop, atBottom, atMax, dual, cntWrite, matchA, matchB;
  logic updNow, immediate, capEvent, outA, outB;

  ////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb
  begin
    mode = {ctlB_q[CTRLB_MODE3_BIT], ctlB_q[CTRLB_MODE2_BIT], ctlA_q[1:0]};
    dual = twm_dual_slope(mode);
    topSrc = TWM_TOP_FIXED;
    updSel = TWM_UPD_IMMEDIATE;
    ovfSel = TWM_OVF_MAX;
    unique case (mode)
      4'd0: ;
      4'd1, 4'd2, 4'd3:
      begin
        updSel = TWM_UPD_TOP;
        ovfSel = TWM_OVF_BOTTOM;
      end
      4'd4: topSrc = TWM_TOP_COMPARE;
      4'd12: topSrc = TWM_TOP_CAPTURE;
      4'd5, 4'd6, 4'd7:
      begin
        updSel = TWM_UPD_BOTTOM;
        ovfSel = TWM_OVF_TOP;
      end
      4'd8, 4'd9:
      begin
        topSrc = mode[0] ? TWM_TOP_COMPARE : TWM_TOP_CAPTURE;
        updSel = TWM_UPD_BOTTOM;
        ovfSel = TWM_OVF_BOTTOM;
      end
      4'd10, 4'd11:
      begin
        topSrc = mode[0] ? TWM_TOP_COMPARE : TWM_TOP_CAPTURE;
        updSel = TWM_UPD_TOP;
        ovfSel = TWM_OVF_BOTTOM;
      end
      4'd14, 4'd15:
      begin
        topSrc = mode[0] ? TWM_TOP_COMPARE : TWM_TOP_CAPTURE;
        updSel = TWM_UPD_BOTTOM;
        ovfSel = TWM_OVF_TOP;
      end
      4'd13: ;  // Reserved: behaves as normal
    endcase
    unique case (topSrc)
      TWM_TOP_COMPARE: top = cmpA;
      TWM_TOP_CAPTURE: top = cap_q;
      default: top = (mode == 4'd0 || mode == 4'd13) ? TOP_MAX : twm_fixed_top(mode);
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Counter, capture, control registers
  always_comb
  begin
    wordIn = {temp_q, writeData};
    cntWrite = countLowWrite;
    temp_d = temp_q;
    if (countHighWrite || compareAHighWrite || compareBHighWrite || captureHighWrite)
    begin
      temp_d = writeData;
    end
    ctlA_d = controlAWrite ? writeData : ctlA_q;
    ctlB_d = controlBWrite ? writeData : ctlB_q;
    immediate = (updSel == TWM_UPD_IMMEDIATE);
    // Blocked during the tick after a counter write
    block_d = cntWrite ? 1'b1 : (timerTick ? 1'b0 : block_q);
    atTop = timerTick && (cnt_q == top) && !(block_q && topSrc != TWM_TOP_FIXED);
    atMax = timerTick && (cnt_q == TOP_MAX);
    atBottom = timerTick && (cnt_q == BOTTOM) && (!dual || down_q);
    matchA = timerTick && !block_q && !cntWrite && (cnt_q == cmpA);
    matchB = timerTick && !block_q && !cntWrite && (cnt_q == cmpB);
    cnt_d = cnt_q;
    down_d = down_q;
    if (cntWrite)
    begin
      cnt_d = wordIn;
    end
    else if (timerTick)
    begin
      if (dual)
      begin
        if (atTop)
        begin
          down_d = 1'b1;
          cnt_d = cnt_q - 16'h0001;
        end
        else if (down_q && cnt_q == BOTTOM)
        begin
          down_d = 1'b0;
          cnt_d = cnt_q + 16'h0001;
        end
        else
        begin
          cnt_d = down_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
        end
      end
      else
      begin
        down_d = 1'b0;
        cnt_d = atTop ? BOTTOM : cnt_q + 16'h0001;
      end
    end
    unique case (updSel)
      TWM_UPD_TOP: updNow = atTop;
      TWM_UPD_BOTTOM: updNow = dual ? atBottom : atTop;
      default: updNow = 1'b0;
    endcase
    unique case (ovfSel)
      TWM_OVF_TOP: ovf_d = atTop;
      TWM_OVF_BOTTOM: ovf_d = atBottom;
      default: ovf_d = atMax;
    endcase
    mA_d = matchA;
    mB_d = matchB;
    capP_d = capEvent && (topSrc != TWM_TOP_CAPTURE);
    cap_d = cap_q;
    if (captureLowWrite)
    begin
      cap_d = wordIn;
    end
    else if (capP_d)
    begin
      cap_d = cnt_q;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      temp_q <= '0;
      cnt_q <= '0;
      cap_q <= '0;
      ctlA_q <= '0;
      ctlB_q <= CTRLB_RESET;
      down_q <= 1'b0;
      block_q <= 1'b0;
      ovf_q <= 1'b0;
      mA_q <= 1'b0;
      mB_q <= 1'b0;
      capP_q <= 1'b0;
    end
    else
    begin
      temp_q <= temp_d;
      cnt_q <= cnt_d;
      cap_q <= cap_d;
      ctlA_q <= ctlA_d;
      ctlB_q <= ctlB_d;
      down_q <= down_d;
      block_q <= block_d;
      ovf_q <= ovf_d;
      mA_q <= mA_d;
      mB_q <= mB_d;
      capP_q <= capP_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Channels and capture
  twm_compare_out chanA (
    .ref_clk(ref_clk),
    .reset(reset),
    .writeStrobe(compareALowWrite),
    .writeData(wordIn),
    .updateNow(updNow),
    .immediate(immediate),
    .matchFire(matchA),
    .forceStrobe(forceStrobeA && !twm_is_pwm(mode)),
    .action(ctlA_q[7:6]),
    .compareValue(cmpA),
    .outState(outA)
  );

  twm_compare_out chanB (
    .ref_clk(ref_clk),
    .reset(reset),
    .writeStrobe(compareBLowWrite),
    .writeData(wordIn),
    .updateNow(updNow),
    .immediate(immediate),
    .matchFire(matchB),
    .forceStrobe(forceStrobeB && !twm_is_pwm(mode)),
    .action(ctlA_q[5:4]),
    .compareValue(cmpB),
    .outState(outB)
  );

  twm_capture_filter capFilter (
    .ref_clk(ref_clk),
    .reset(reset),
    .capturePin(capture_input_pin),
    .filterEnable(ctlB_q[CTRLB_FILTER_BIT]),
    .edgeRising(ctlB_q[CTRLB_EDGE_BIT]),
    .captureEvent(capEvent)
  );

  assign count_value = cnt_q;
  assign capture_value = cap_q;
  assign timer1_control_b = ctlB_q;
  assign controlA = ctlA_q;
  assign compare_output_a = outA;
  assign compare_output_b = outB;
  assign overflowPulse = ovf_q;
  assign compareMatchPulseA = mA_q;
  assign compareMatchPulseB = mB_q;
  assign capturePulse = capP_q;
endmodule

//--- testbench/twm_timer16_asserts.sv
/*
  Port assertions for the timer waveform-mode block.
  Assumes a bind onto twm_timer16; one clock, synchronous reset.
*/
module twm_timer16_asserts
  import twm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic timerTick,
  input wire logic [7:0] writeData,
  input wire logic countHighWrite,
  input wire logic countLowWrite,
  input wire logic controlAWrite,
  input wire logic controlBWrite,
  input wire logic forceStrobeA,
  input wire logic forceStrobeB,
  input wire logic [15:0] count_value,
  input wire logic [7:0] timer1_control_b,
  input wire logic [7:0] controlA,
  input wire logic compare_output_a,
  input wire logic compare_output_b,
  input wire logic overflowPulse,
  input wire logic compareMatchPulseA,
  input wire logic compareMatchPulseB
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mode;
  logic [15:0] fixTop;
  logic block_q;
  logic block_d;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  assign mode = {timer1_control_b[4:3], controlA[1:0]};
  assign fixTop = mode[1] ? (mode[0] ? TOP_10BIT : TOP_9BIT) : TOP_8BIT;
  ////////////////////////////////////////
  // Pending block after a count write
  always_comb
  begin
    block_d = block_q;
    if (timerTick)
      block_d = 1'b0;
    if (countLowWrite)
      block_d = 1'b1;
  end
  always_ff @(posedge ref_clk)
    block_q <= reset ? 1'b0 : block_d;
  ////////////////////////////////////////
  sequence s_lockTick;
    timerTick && (block_q || countLowWrite);
  endsequence
  sequence s_pair;
    countHighWrite ##1 countLowWrite && !timerTick;
  endsequence
  property p_block;
    s_lockTick |=> !compareMatchPulseA && !compareMatchPulseB;
  endproperty
  property p_commit;
    s_pair |=> count_value == {$past(writeData, 2), $past(writeData)};
  endproperty
  property p_force;
    forceStrobeA && !timerTick && !countLowWrite |=> !compareMatchPulseA && $stable(count_value);
  endproperty
  property p_hold;
    (controlAWrite || controlBWrite) && !timerTick && !$past(timerTick)
      && !forceStrobeA && !forceStrobeB |=> $stable(compare_output_a) && $stable(compare_output_b);
  endproperty
  property p_ctrlB;
    controlBWrite |=> timer1_control_b[7:3] == $past(writeData[7:3]);
  endproperty
  property p_reset;
    disable iff (1'b0) reset |=> timer1_control_b == CTRLB_RESET && controlA == 8'h00;
  endproperty
  property p_ovfNorm;
    overflowPulse && mode == 4'h0 |-> count_value <= 16'h0001;
  endproperty
  property p_normWrap;
    mode == 4'h0 && timerTick && count_value == TOP_MAX && !countLowWrite |=> count_value == BOTTOM;
  endproperty
  property p_fastTop;
    mode inside {4'h5, 4'h6, 4'h7} && timerTick && count_value == fixTop && !countLowWrite
      |=> count_value == BOTTOM;
  endproperty
  property p_dualTop;
    mode inside {4'h1, 4'h2, 4'h3} && timerTick && count_value == fixTop && !countLowWrite
      |=> count_value == fixTop - 16'h0001;
  endproperty
  a_block: assert property (p_block) else $error("match after count write");
  a_commit: assert property (p_commit) else $error("count commit wrong");
  a_force: assert property (p_force) else $error("force set flag or count");
  a_hold: assert property (p_hold) else $error("output moved on write");
  a_ctrlB: assert property (p_ctrlB) else $error("control B readback");
  a_reset: assert property (p_reset) else $error("reset values");
  a_ovfNorm: assert property (p_ovfNorm) else $error("overflow not at MAX");
  a_normWrap: assert property (p_normWrap) else $error("normal wrap");
  a_fastTop: assert property (p_fastTop) else $error("fast PWM wrap");
  a_dualTop: assert property (p_dualTop) else $error("dual slope turn");
endmodule

//--- testbench/testbench.sv
/*
  Self-checking bench for the timer waveform-mode block.
  Assumes the package, design and checker are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import twm_pkg::*;
  logic ref_clk = 0;
  logic reset = 1;
  logic timerTick = 0;
  logic capture_input_pin = 0;
  logic [7:0] writeData = 8'h00;
  logic [11:0] st = 12'h000;
  logic [15:0] count_value, capture_value, r;
  logic [7:0] timer1_control_b, controlA;
  logic compare_output_a, compare_output_b, overflowPulse;
  logic compareMatchPulseA, compareMatchPulseB, capturePulse;
  int mismatches = 0;
  int checked = 0;
  logic [3:0] notes [$];
  logic [1:0] acts [5] = '{ACT_SET, ACT_TOGGLE, ACT_CLEAR, ACT_TOGGLE, ACT_NONE};
  logic [4:0] fexp = 5'h19;
  logic [3:0] tm [9] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h4, 4'h1, 4'hF, 4'h9, 4'hB};
  logic [15:0] ts [9] = '{16'hFFFE, 16'h00FE, 16'h01FE, 16'h03FE, 16'h000E, 16'h0002,
    16'h000E, 16'h000E, 16'h000E};
  int tn [9] = '{2, 2, 2, 2, 3, 508, 3, 18, 18};
  logic [8:0] tq [9] = '{9'h004, 9'h004, 9'h004, 9'h004, 9'h001, 9'h109,
    9'h005, 9'h021, 9'h021};
  always #5 ref_clk = ~ref_clk;
  twm_timer16 u_twm_timer16 (.ref_clk(ref_clk), .reset(reset), .timerTick(timerTick),
    .writeData(writeData), .countHighWrite(st[0]), .countLowWrite(st[1]),
    .compareAHighWrite(st[2]), .compareALowWrite(st[3]), .compareBHighWrite(st[4]),
    .compareBLowWrite(st[5]), .captureHighWrite(st[6]), .captureLowWrite(st[7]),
    .controlAWrite(st[8]), .controlBWrite(st[9]), .forceStrobeA(st[10]),
    .forceStrobeB(st[11]), .capture_input_pin(capture_input_pin), .count_value(count_value),
    .capture_value(capture_value), .timer1_control_b(timer1_control_b), .controlA(controlA),
    .compare_output_a(compare_output_a), .compare_output_b(compare_output_b),
    .overflowPulse(overflowPulse), .compareMatchPulseA(compareMatchPulseA),
    .compareMatchPulseB(compareMatchPulseB), .capturePulse(capturePulse));
  ////////////////////////////////////////
  task automatic step(input logic [11:0] s, input logic [7:0] d, input logic t);
    @(posedge ref_clk);
    #1;
    st = s;
    writeData = d;
    timerTick = t;
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    step(12'h001 << i, d, 1'b0);
    step(12'h000, 8'h00, 1'b0);
  endtask
  task automatic wr16(input int i, input logic [15:0] v);
    step(12'h001 << i, v[15:8], 1'b0);
    wr(i + 1, v[7:0]);
  endtask
  task automatic ticks(input int n);
    repeat (n) step(12'h000, 8'h00, 1'b1);
    repeat (2) step(12'h000, 8'h00, 1'b0);
  endtask
  task automatic pinTo(input logic v, input int n);
    @(posedge ref_clk);
    #1;
    capture_input_pin = v;
    repeat (n) step(12'h000, 8'h00, 1'b0);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(posedge ref_clk)
    if (!reset && (overflowPulse || capturePulse || compareMatchPulseA || compareMatchPulseB))
      chk("pulse", {12'h000, notes.size() ? notes.pop_front() : 4'h0},
        {12'h000, compareMatchPulseB, overflowPulse, capturePulse,
        compareMatchPulseA});
  initial
  begin
    #50000;
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'h54D307B5));
    repeat (4) @(posedge ref_clk);
    #1;
    reset = 0;
    chk("ctrlB", {8'h00, CTRLB_RESET}, {8'h00, timer1_control_b});
    chk("ctrlA", 16'h0000, {8'h00, controlA});
    done("reset");
    wr16(4, 16'h001F);
    r = 16'($urandom());
    wr16(6, r);
    chk("capture", r, capture_value);
    step(12'h001, 8'hA5, 1'b0);
    wr(7, 8'h5A);
    chk("capture", 16'hA55A, capture_value);
    r = 16'($urandom());
    wr16(0, r);
    chk("count", r, count_value);
    wr(9, 8'hC0);
    chk("ctrlB", 16'h00C0, {8'h00, timer1_control_b});
    done("registers");
    for (int k = 0; k < 5; k++)
    begin
      wr(8, {acts[k], acts[k], 4'h0});
      step(12'hC00, 8'h00, 1'b0);
      repeat (2) step(12'h000, 8'h00, 1'b0);
      chk("outs", {14'h0000, fexp[k], fexp[k]},
        {14'h0000, compare_output_a, compare_output_b});
    end
    chk("count", r, count_value);
    wr(8, 8'h41);
    step(12'h400, 8'h00, 1'b0);
    repeat (2) step(12'h000, 8'h00, 1'b0);
    chk("outA", 16'h0001, {15'h0000, compare_output_a});
    done("force");
    wr(8, 8'h40);
    wr16(2, 16'h0020);
    wr16(0, 16'h0020);
    ticks(1);
    chk("outA", 16'h0001, {15'h0000, compare_output_a});
    wr16(0, 16'h001E);
    notes.push_back(4'h8);
    notes.push_back(4'h1);
    ticks(3);
    chk("outA", 16'h0000, {15'h0000, compare_output_a});
    done("blocking");
    wr(8, 8'h00);
    wr16(0, 16'h0123);
    wr(9, 8'h40);
    notes.push_back(4'h2);
    pinTo(1'b1, 8);
    chk("capture", 16'h0123, capture_value);
    pinTo(1'b0, 8);
    wr(9, 8'hC0);
    pinTo(1'b1, 2);
    pinTo(1'b0, 8);
    notes.push_back(4'h2);
    pinTo(1'b1, 8);
    wr(9, 8'h80);
    notes.push_back(4'h2);
    pinTo(1'b0, 8);
    done("capture");
    wr16(2, 16'h0010);
    wr16(4, 16'h4000);
    for (int k = 0; k < 9; k++)
    begin
      wr(9, {3'h0, tm[k][3:2], 3'h0});
      wr(8, {6'h00, tm[k][1:0]});
      wr16(0, ts[k]);
      for (int j = 0; j < 9; j += 3)
        if (tq[k][j +: 3] != 3'h0)
          notes.push_back(4'(tq[k][j +: 3]));
      ticks(tn[k]);
      chk("wrap", BOTTOM, count_value);
      ticks(1);
    end
    chk("notes", 16'h0000, 16'(notes.size()));
    done("modes");
    tally_and_finish();
  end
endmodule
bind twm_timer16 twm_timer16_asserts u_twm_timer16_asserts (.ref_clk(ref_clk), .reset(reset),
  .timerTick(timerTick), .writeData(writeData), .countHighWrite(countHighWrite),
  .countLowWrite(countLowWrite), .controlAWrite(controlAWrite), .controlBWrite(controlBWrite),
  .forceStrobeA(forceStrobeA), .forceStrobeB(forceStrobeB), .count_value(count_value),
  .timer1_control_b(timer1_control_b), .controlA(controlA),
  .compare_output_a(compare_output_a), .compare_output_b(compare_output_b),
  .overflowPulse(overflowPulse), .compareMatchPulseA(compareMatchPulseA),
  .compareMatchPulseB(compareMatchPulseB));
